// *** design/tmrcp_consts.vh ***
// Constants for the timer clock and prescale control block
`ifndef TMRCP_CONSTS_VH
`define TMRCP_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define TMRCP_IDX_CTRL      10'h005
// Control byte address is four times its word index
`define TMRCP_OFF_CTRL      {`TMRCP_IDX_CTRL, 2'b00}
`define TMRCP_OFF_CNT_LO    12'h008
`define TMRCP_OFF_CNT_HI    12'h00C
`define TMRCP_OFF_STAT      12'h010
`define TMRCP_OFF_MASK      12'h018
`define TMRCP_ADDR_W        12

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define TMRCP_CTRL_RST      8'h00
`define TMRCP_CTRL_WMASK    8'hFE
`define TMRCP_BIT_IRQEDG    7
`define TMRCP_BIT_CLKEDG    6
`define TMRCP_BIT_CLKSRC    5
`define TMRCP_PS_HI         4
`define TMRCP_PS_LO         1
`define TMRCP_PS_TOP        3

// ----------------------------------------------------------------------
// Status and mask fields
// ----------------------------------------------------------------------
`define TMRCP_NEV           3
`define TMRCP_EV_IRQPIN     0
`define TMRCP_EV_CLKPIN     1
`define TMRCP_EV_OVF        2
`define TMRCP_EV_RST        3'h0

// ----------------------------------------------------------------------
// Counter sizes
// ----------------------------------------------------------------------
`define TMRCP_CNT_W         16
`define TMRCP_PRE_W         8
`define TMRCP_CNT_RST       16'h0000
`define TMRCP_PRE_RST       8'h00
`define TMRCP_PS_MAX        8'hFF

`endif

// *** design/tmrcp_edge_det.v ***
// Edge detector with selectable polarity for one pin
`timescale 1ns/1ps
`default_nettype none
`include "tmrcp_consts.vh"

module tmrcp_edge_det (
   // Clock, reset and enable
   input  wire CORE_CLK_I,
   input  wire RST_B_I,
   input  wire CLK_EN_I,
   // Pin and polarity
   input  wire PIN_I,
   input  wire RISE_SEL_I,
   // Event
   output wire EDGE_O
);

   reg pin_d_ff;

   // Previous pin sample
   always @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         pin_d_ff <= 1'b0;
      end else if (CLK_EN_I) begin
         pin_d_ff <= PIN_I;
      end
   end

   // Selected edge, one cycle pulse
   assign EDGE_O = CLK_EN_I & (RISE_SEL_I ? (PIN_I & ~pin_d_ff)
                                          : (~PIN_I & pin_d_ff));

endmodule // tmrcp_edge_det
`default_nettype wire

// *** design/tmrcp_top.v ***
// Timer clock source, edge and prescale control with APB registers
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tmrcp_consts.vh"

module tmrcp_top (
   // Clock, reset and enable
   input  wire        CORE_CLK_I,
   input  wire        RST_B_I,
   input  wire        CLK_EN_I,
   // APB slave
   input  wire        PSEL_I,
   input  wire        PENABLE_I,
   input  wire        PWRITE_I,
   input  wire [11:0] PADDR_I,
   input  wire [31:0] PWDATA_I,
   input  wire [3:0]  PSTRB_I,
   output reg  [31:0] PRDATA_O,
   output wire        PREADY_O,
   output wire        PSLVERR_O,
   // Pins
   input  wire        EXT_IRQ_PIN_I,
   input  wire        EXT_TIMER_CLOCK_PIN_I,
   // Events and state
   output wire        EXT_IRQ_FLAG_SET_O,
   output wire        CLOCK_PIN_EVENT_FLAG_SET_O,
   output wire        TIMER_OVF_O,
   output wire [15:0] MAIN_TIMER_COUNT_O,
   output wire        IRQ_O
);

   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   reg  [7:0]  ctrl_ff;
   reg  [15:0] cnt_ff;
   reg  [15:0] nxt_cnt;
   reg  [7:0]  pre_ff;
   reg  [7:0]  nxt_pre;
   reg  [2:0]  stat_ff;
   reg  [2:0]  mask_ff;
   reg  [2:0]  nxt_stat;
   reg  [7:0]  ratio_m1;
   reg  [31:0] rd_data;
   reg         addr_ok;
   reg         ovf_ff;
   wire        acc;
   wire        wr_acc;
   wire        rd_setup;
   wire        irq_edge;
   wire        clk_pin_edge;
   wire        tick;
   wire        adv;
   wire        wr_lo;
   wire        wr_hi;
   wire [2:0]  ev;
   wire [3:0]  ps;

   // -------------------------------------------------------------------
   // APB decode
   // -------------------------------------------------------------------

   // Zero wait state slave
   assign acc       = PSEL_I & PENABLE_I & CLK_EN_I;
   assign wr_acc    = acc & PWRITE_I;
   assign rd_setup  = PSEL_I & ~PENABLE_I & ~PWRITE_I & CLK_EN_I;
   assign PREADY_O  = 1'b1;
   assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_ok;

   // Address check
   always @* begin
      case (PADDR_I)
         `TMRCP_OFF_CTRL,
         `TMRCP_OFF_CNT_LO,
         `TMRCP_OFF_CNT_HI,
         `TMRCP_OFF_STAT,
         `TMRCP_OFF_MASK: addr_ok = 1'b1;
         default:         addr_ok = 1'b0;
      endcase
   end

   // Byte access to the counter halves
   assign wr_lo = wr_acc & PSTRB_I[0] & (PADDR_I == `TMRCP_OFF_CNT_LO);
   assign wr_hi = wr_acc & PSTRB_I[0] & (PADDR_I == `TMRCP_OFF_CNT_HI);

   // -------------------------------------------------------------------
   // Control register
   // -------------------------------------------------------------------

   // Unbanked control register, bit 0 never stored
   always @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ctrl_ff <= `TMRCP_CTRL_RST;
      end else if (wr_acc && PSTRB_I[0] &&
                   PADDR_I == `TMRCP_OFF_CTRL) begin
         ctrl_ff <= PWDATA_I[7:0] & `TMRCP_CTRL_WMASK;
      end
   end

   assign ps = ctrl_ff[`TMRCP_PS_HI:`TMRCP_PS_LO];

   // -------------------------------------------------------------------
   // Pin edge detection
   // -------------------------------------------------------------------

   // Interrupt pin edge
   tmrcp_edge_det u_irq_edge (
      .CORE_CLK_I (CORE_CLK_I),
      .RST_B_I    (RST_B_I),
      .CLK_EN_I   (CLK_EN_I),
      .PIN_I      (EXT_IRQ_PIN_I),
      .RISE_SEL_I (ctrl_ff[`TMRCP_BIT_IRQEDG]),
      .EDGE_O     (irq_edge)
   );

   // External clock pin edge
   tmrcp_edge_det u_clk_edge (
      .CORE_CLK_I (CORE_CLK_I),
      .RST_B_I    (RST_B_I),
      .CLK_EN_I   (CLK_EN_I),
      .PIN_I      (EXT_TIMER_CLOCK_PIN_I),
      .RISE_SEL_I (ctrl_ff[`TMRCP_BIT_CLKEDG]),
      .EDGE_O     (clk_pin_edge)
   );

   // Source select, edge bit ignored on internal clock
   assign tick = ctrl_ff[`TMRCP_BIT_CLKSRC] ? CLK_EN_I
                                            : clk_pin_edge;

   // -------------------------------------------------------------------
   // Prescaler and counter
   // -------------------------------------------------------------------

   // Ratio minus one from prescale code
   always @* begin
      if (ps[`TMRCP_PS_TOP]) begin
         ratio_m1 = `TMRCP_PS_MAX;
      end else begin
         ratio_m1 = (8'h01 << ps[2:0]) - 8'h01;
      end
   end

   assign adv = tick & (pre_ff >= ratio_m1);

   // Next prescaler and count
   always @* begin
      nxt_pre = pre_ff;
      nxt_cnt = cnt_ff;
      if (tick) begin
         nxt_pre = adv ? `TMRCP_PRE_RST : (pre_ff + 8'h01);
      end
      if (adv) begin
         nxt_cnt = cnt_ff + 16'h0001;
      end
      if (wr_lo) begin
         nxt_cnt = {cnt_ff[15:8], PWDATA_I[7:0]};
         nxt_pre = `TMRCP_PRE_RST;
      end
      if (wr_hi) begin
         nxt_cnt = {PWDATA_I[7:0], cnt_ff[7:0]};
         nxt_pre = `TMRCP_PRE_RST;
      end
   end

   // Counter state
   always @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         pre_ff <= `TMRCP_PRE_RST;
         cnt_ff <= `TMRCP_CNT_RST;
         ovf_ff <= 1'b0;
      end else if (CLK_EN_I) begin
         pre_ff <= nxt_pre;
         cnt_ff <= nxt_cnt;
         ovf_ff <= adv & (&cnt_ff) & ~wr_lo & ~wr_hi;
      end
   end

   assign MAIN_TIMER_COUNT_O = cnt_ff;
   assign TIMER_OVF_O        = ovf_ff;

   // Raw event pulses
   assign EXT_IRQ_FLAG_SET_O         = irq_edge;
   assign CLOCK_PIN_EVENT_FLAG_SET_O = clk_pin_edge &
                                       ~ctrl_ff[`TMRCP_BIT_CLKSRC];

   // -------------------------------------------------------------------
   // Interrupt status and mask
   // -------------------------------------------------------------------

   assign ev = {ovf_ff, CLOCK_PIN_EVENT_FLAG_SET_O, irq_edge};

   // Sticky status per event, set beats clear
   genvar gi;
   generate
      for (gi = 0; gi < `TMRCP_NEV; gi = gi + 1) begin : g_stat
         always @* begin
            nxt_stat[gi] = stat_ff[gi];
            if (wr_acc && PSTRB_I[0] && PADDR_I == `TMRCP_OFF_STAT &&
                PWDATA_I[gi]) begin
               nxt_stat[gi] = 1'b0;
            end
            if (ev[gi]) begin
               nxt_stat[gi] = 1'b1;
            end
         end
      end
   endgenerate

   // Status and mask registers
   always @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         stat_ff <= `TMRCP_EV_RST;
         mask_ff <= `TMRCP_EV_RST;
      end else if (CLK_EN_I) begin
         stat_ff <= nxt_stat;
         if (wr_acc && PSTRB_I[0] && PADDR_I == `TMRCP_OFF_MASK) begin
            mask_ff <= PWDATA_I[2:0];
         end
      end
   end

   assign IRQ_O = |(stat_ff & mask_ff);

   // -------------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------------

   // Read mux
   always @* begin
      case (PADDR_I)
         `TMRCP_OFF_CTRL:   rd_data = {24'h000000, ctrl_ff[7:1], 1'b0};
         `TMRCP_OFF_CNT_LO: rd_data = {24'h000000, cnt_ff[7:0]};
         `TMRCP_OFF_CNT_HI: rd_data = {24'h000000, cnt_ff[15:8]};
         `TMRCP_OFF_STAT:   rd_data = {29'h0000000, stat_ff};
         `TMRCP_OFF_MASK:   rd_data = {29'h0000000, mask_ff};
         default:           rd_data = 32'h00000000;
      endcase
   end

   // Registered read data, loaded in setup phase
   always @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         PRDATA_O <= 32'h00000000;
      end else if (rd_setup) begin
         PRDATA_O <= rd_data;
      end
   end

endmodule // tmrcp_top
`default_nettype wire

// *** test/tmrcp_chk_assertions.sv ***
// Port checker for the timer control block
`timescale 1ns/1ps
`default_nettype none
module tmrcp_chk (
   // Clock, reset and APB
   input wire logic        CORE_CLK_I,
   input wire logic        RST_B_I,
   input wire logic        PSEL_I,
   input wire logic        PENABLE_I,
   input wire logic        PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic        PSLVERR_O,
   input wire logic        PREADY_O,
   // Pins and events
   input wire logic        EXT_IRQ_PIN_I,
   input wire logic        EXT_TIMER_CLOCK_PIN_I,
   input wire logic        EXT_IRQ_FLAG_SET_O,
   input wire logic        CLOCK_PIN_EVENT_FLAG_SET_O,
   input wire logic        TIMER_OVF_O,
   input wire logic [15:0] MAIN_TIMER_COUNT_O
);
   logic [7:0]  ctrl_ff;
   logic        acc, wcnt, mapd;
   logic [15:0] cnt;
   // Access phase, count writes and mapped places
   assign acc = PSEL_I & PENABLE_I;
   assign wcnt = acc & PWRITE_I & (PADDR_I[11:3] == 9'h001);
   assign mapd = PADDR_I inside {12'h014, 12'h008, 12'h00C, 12'h010, 12'h018};
   assign cnt = MAIN_TIMER_COUNT_O;
   // Shadow copy of the control register
   always @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) ctrl_ff <= 8'h00;
      else if (acc && PWRITE_I && PADDR_I == 12'h014)
         ctrl_ff <= PWDATA_I[7:0];
   end
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_B_I);
   a_unmap_err: assert property (acc && !mapd |-> PSLVERR_O)
      else $error("no error on unmapped place");
   a_map_ok: assert property (acc && mapd |-> !PSLVERR_O)
      else $error("error on mapped place");
   a_ready_access: assert property (acc |-> PREADY_O)
      else $error("slave not ready in access");
   a_ctrl_read: assert property (acc && !PWRITE_I && PADDR_I == 12'h014
      |-> PRDATA_O == {24'h0, ctrl_ff & 8'hFE}) else $error("bad control read");
   a_irq_edge: assert property (EXT_IRQ_FLAG_SET_O |-> (ctrl_ff[7]
      ? $rose(EXT_IRQ_PIN_I) : $fell(EXT_IRQ_PIN_I))) else $error("irq edge");
   a_int_quiet: assert property (ctrl_ff[5]
      |-> !CLOCK_PIN_EVENT_FLAG_SET_O) else $error("pin event on internal");
   a_clk_edge: assert property (CLOCK_PIN_EVENT_FLAG_SET_O |-> (ctrl_ff[6]
      ? $rose(EXT_TIMER_CLOCK_PIN_I) : $fell(EXT_TIMER_CLOCK_PIN_I)))
      else $error("clock pin edge");
   a_cnt_step: assert property (cnt != $past(cnt) && !$past(wcnt)
      |-> cnt == $past(cnt) + 16'h1) else $error("count jump");
   a_ovf_wrap: assert property ($past(cnt) == 16'hFFFF && cnt == 16'h0
      && !$past(wcnt) |-> ##[0:1] TIMER_OVF_O) else $error("no overflow");
   cover property (TIMER_OVF_O);
   cover property (EXT_IRQ_FLAG_SET_O);
   cover property (CLOCK_PIN_EVENT_FLAG_SET_O);
endmodule // tmrcp_chk
`default_nettype wire

// *** test/tmrcp_pins.sv ***
// Pin source model: external clock pin and interrupt pin
`timescale 1ns/1ps
`default_nettype none
module tmrcp_pins (
   // Clock and commands
   input  wire logic clk_i,
   input  wire logic run_i,
   input  wire logic irq_i,
   // Pins
   output var  logic clk_pin_o = 1'b0,
   output var  logic irq_pin_o = 1'b0
);
   logic [1:0] ph_ff = 2'h0;
   // Pin clock toggles every fourth cycle while running, else stands still
   always @(posedge clk_i) begin
      ph_ff <= ph_ff + 2'h1;
      if (run_i && ph_ff == 2'h3) clk_pin_o <= ~clk_pin_o;
      irq_pin_o <= irq_i;
   end
endmodule // tmrcp_pins
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the timer control block
`timescale 1ns/1ps
`default_nettype none
`include "tmrcp_consts.vh"
module tb_top;
   logic        clk, rst_b, psel, pen, pwr, run, irq_drv, en;
   logic        slverr, ipin, cpin, iflag, cflag, ovf, irq, rdy;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] cnt;
   logic [15:0] hold;
   logic [7:0]  c;
   logic [31:0] exp_q[$];
   int          bad_count, tests_run, cyc;
   tmrcp_top dut (
      .CORE_CLK_I(clk), .RST_B_I(rst_b), .CLK_EN_I(en),
      .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PSTRB_I(4'h1), .PRDATA_O(prdata),
      .PREADY_O(rdy), .PSLVERR_O(slverr), .EXT_IRQ_PIN_I(ipin),
      .EXT_TIMER_CLOCK_PIN_I(cpin), .EXT_IRQ_FLAG_SET_O(iflag),
      .CLOCK_PIN_EVENT_FLAG_SET_O(cflag), .TIMER_OVF_O(ovf),
      .MAIN_TIMER_COUNT_O(cnt), .IRQ_O(irq));
   tmrcp_pins u_pins (.clk_i(clk), .run_i(run), .irq_i(irq_drv),
      .clk_pin_o(cpin), .irq_pin_o(ipin));
   always #2.5 clk = ~clk;
   // Compare one value and count the outcome
   task automatic check(string n, logic [31:0] s, logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One APB transfer, entered just after a rising edge
   task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(logic [11:0] a, logic [31:0] e);
      exp_q.push_back(e);
      xfer(1'b0, a, 32'h0);
   endtask
   // Settled level of the interrupt output
   task automatic lvl(logic v);
      @(negedge clk);
      check("irq", 32'(irq), 32'(v));
      @(posedge clk);
   endtask
   task automatic pin(logic v);
      irq_drv <= v;
      repeat (4) @(posedge clk);
   endtask
   // Cycles between two count steps
   task automatic gap(int r);
      int n = 0;
      logic [15:0] v;
      @(negedge clk);
      v = cnt;
      while (cnt === v) @(negedge clk);
      v = cnt;
      while (cnt === v) begin
         @(negedge clk);
         n++;
      end
      check("ratio", 32'(n), 32'(r));
      @(posedge clk);
   endtask
   // Read data against the oldest note; run-length guard
   always @(posedge clk) begin
      if (psel && pen && !pwr && rdy === 1'b1)
         check("rdata", prdata, exp_q.pop_front());
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         finish_test();
      end
   end
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      {psel, pen, pwr, run, irq_drv, en} = 6'h01;
      paddr = 12'h000;
      pwdata = 32'h0;
      void'($urandom(32'h6051));
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(`TMRCP_OFF_CTRL, 32'h0);
      rd(`TMRCP_OFF_CNT_LO, 32'h0);
      rd(12'h020, 32'h0);
      // Internal clock, every prescale code, random edge and bit 0
      for (int i = 0; i < 16; i++) begin
         c = {1'b0, 1'($urandom), 1'b1, 4'(i), 1'($urandom)};
         xfer(1'b1, `TMRCP_OFF_CTRL, 32'(c));
         rd(`TMRCP_OFF_CTRL, 32'(c & 8'hFE));
         xfer(1'b1, `TMRCP_OFF_CNT_LO, 32'h0);
         gap(i > 7 ? 256 : 1 << i);
      end
      // External pin, both edges, seven pin changes
      for (int e = 0; e < 2; e++) begin
         xfer(1'b1, `TMRCP_OFF_CTRL, 32'(e << 6));
         xfer(1'b1, `TMRCP_OFF_CNT_LO, 32'h0);
         xfer(1'b1, `TMRCP_OFF_CNT_HI, 32'h0);
         c = 8'(cpin);
         run <= 1'b1;
         repeat (28) @(posedge clk);
         run <= 1'b0;
         repeat (4) @(posedge clk);
         rd(`TMRCP_OFF_CNT_LO, 32'(3 + (e ^ c)));
      end
      // Interrupt edge, mask and clear
      xfer(1'b1, `TMRCP_OFF_STAT, 32'h7);
      xfer(1'b1, `TMRCP_OFF_MASK, 32'h1);
      xfer(1'b1, `TMRCP_OFF_CTRL, 32'h80);
      pin(1'b1);
      rd(`TMRCP_OFF_STAT, 32'h1);
      lvl(1'b1);
      xfer(1'b1, `TMRCP_OFF_MASK, 32'h0);
      lvl(1'b0);
      xfer(1'b1, `TMRCP_OFF_STAT, 32'h1);
      pin(1'b0);
      rd(`TMRCP_OFF_STAT, 32'h0);
      xfer(1'b1, `TMRCP_OFF_CTRL, 32'h0);
      pin(1'b1);
      rd(`TMRCP_OFF_STAT, 32'h0);
      pin(1'b0);
      rd(`TMRCP_OFF_STAT, 32'h1);
      // Count wraps and flags an overflow
      xfer(1'b1, `TMRCP_OFF_STAT, 32'h7);
      xfer(1'b1, `TMRCP_OFF_MASK, 32'h4);
      xfer(1'b1, `TMRCP_OFF_CTRL, 32'h20);
      xfer(1'b1, `TMRCP_OFF_CNT_HI, 32'hFF);
      xfer(1'b1, `TMRCP_OFF_CNT_LO, 32'hF0);
      repeat (40) @(posedge clk);
      rd(`TMRCP_OFF_STAT, 32'h4);
      lvl(1'b1);
      // Enable low freezes the running count, high resumes it
      en <= 1'b0;
      @(negedge clk);
      hold = cnt;
      repeat (20) @(negedge clk);
      check("frozen", 32'(cnt), 32'(hold));
      @(posedge clk);
      en <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check("resume", 32'(cnt), 32'(hold + 16'h0002));
      @(posedge clk);
      finish_test();
   end
endmodule // tb_top
bind tmrcp_top tmrcp_chk u_chk (
   .CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I),
   .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
   .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O),
   .PREADY_O(PREADY_O),
   .EXT_IRQ_PIN_I(EXT_IRQ_PIN_I),
   .EXT_TIMER_CLOCK_PIN_I(EXT_TIMER_CLOCK_PIN_I),
   .EXT_IRQ_FLAG_SET_O(EXT_IRQ_FLAG_SET_O),
   .CLOCK_PIN_EVENT_FLAG_SET_O(CLOCK_PIN_EVENT_FLAG_SET_O),
   .TIMER_OVF_O(TIMER_OVF_O), .MAIN_TIMER_COUNT_O(MAIN_TIMER_COUNT_O));
`default_nettype wire
